// ==== core/talu_unit.v ====
// token-driven arithmetic/logic processing unit with register slave
// Functional notes
// - drop instruction bits 12, 13 before arithmetic
// - full_left 0: one operand; 1: two
// - operand_swap exchanges A and B on entry
// - output_format picks one or two tokens
// - each output is data, condition, sign
// - branch_select adds one to the id of condition-true tokens
// - cond_skip with unequal conditions gives no-op
// - test true sets both conditions, else clears
// - eight test codes; none copies input conditions
// - OR, AND, XOR, complement-A AND B
// - 01100 complements A, ignores B
// - arithmetic operands are 17-bit signed values
// - add/subtract to X, Y normally zero
// - overflow Y plus one, underflow minus one
// - multiply: upper half X, lower Y
// - 11011 passes A to X, B to Y
// - 5-bit opcode, shifts and reversed variants
// - shift-count variants put leading zeros in Y
// - increment/decrement A with overflow on Y
// - barrel shift by B low bits, B sign direction
`timescale 1ns/1ns
`include "taluv_regs.vh"

module talu_unit (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire in_valid,
    output wire in_ready,
    input wire [13:0] in_instr,
    input wire [`TALU_ID_W-1:0] in_id,
    input wire [15:0] a_data,
    input wire a_sign,
    input wire a_cond,
    input wire [15:0] b_data,
    input wire b_sign,
    input wire b_cond,
    output wire out_valid,
    input wire out_ready,
    output reg [`TALU_ID_W-1:0] out_id,
    output reg [15:0] out_data,
    output reg out_sign,
    output reg out_cond
);
// ****************************************
// register slave
// ****************************************
reg aw_q;
reg [3:0] awaddr_q;
reg w_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg enable_q;
reg [15:0] count_q;
reg [1:0] state_q;
wire wr_go = aw_q && w_q && !s_axi_bvalid;

assign s_axi_awready = !aw_q;
assign s_axi_wready = !w_q;
assign s_axi_arready = !s_axi_rvalid;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_q <= 1'b0;
        awaddr_q <= 4'h0;
        w_q <= 1'b0;
        wdata_q <= 32'h0;
        wstrb_q <= 4'h0;
        enable_q <= `TALU_CTRL_RST;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `TALU_RESP_OK;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `TALU_RESP_OK;
        s_axi_rdata <= 32'h0;
    end
    else
    begin
        if (s_axi_awvalid && !aw_q)
        begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q)
        begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        if (wr_go)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `TALU_RESP_OK;
            if ({awaddr_q[3:2], 2'h0} == `TALU_REG_CTRL && wstrb_q[0])
                enable_q <= wdata_q[0];
            if ({awaddr_q[3:2], 2'h0} != `TALU_REG_CTRL &&
                {awaddr_q[3:2], 2'h0} != `TALU_REG_STAT)
                s_axi_bresp <= `TALU_RESP_ERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `TALU_RESP_OK;
            case ({s_axi_araddr[3:2], 2'h0})
            `TALU_REG_CTRL: s_axi_rdata <= {31'h0, enable_q};
            `TALU_REG_STAT:
                s_axi_rdata <= {count_q, 14'h0, state_q};
            default:
            begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= `TALU_RESP_ERR;
            end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end
// ****************************************
// operand preparation
// ****************************************
wire swap = in_instr[`TALU_SWAP_BIT];
wire full = in_instr[`TALU_FULL_BIT];
wire [11:0] ins = in_instr[11:0];
wire [4:0] op_raw = ins[`TALU_OP_MSB:`TALU_OP_LSB];
wire [2:0] tst = ins[`TALU_TST_MSB:`TALU_TST_LSB];
wire skip_en = ins[`TALU_SKIP_BIT];
wire branch_select = ins[`TALU_BRC_BIT];
wire [1:0] fmt = ins[`TALU_FMT_MSB:`TALU_FMT_LSB];
// one-operand instructions see no B token
wire [16:0] b_in = full ? {b_sign, b_data} : 17'h0;
wire [16:0] pa = swap ? b_in : {a_sign, a_data};
wire [16:0] pb = swap ? {a_sign, a_data} : b_in;
wire pac = swap ? b_cond & full : a_cond;
wire pbc = swap ? a_cond : b_cond & full;
wire [4:0] op = (skip_en && (pac != pbc)) ? `TALU_OP_NOP : op_raw;
// ****************************************
// datapath
// ****************************************
wire signed [17:0] sum = {pa[16], pa} + {pb[16], pb};
wire signed [17:0] dif = {pa[16], pa} - {pb[16], pb};
wire signed [17:0] inc = {pa[16], pa} + 18'h00001;
wire signed [17:0] dec = {pa[16], pa} - 18'h00001;
wire signed [33:0] prod = $signed(pa) * $signed(pb);
wire [4:0] shn = pb[4] ? 5'h10 : pb[4:0];
wire [31:0] shr = {pa[15:0], 16'h0} >> shn;
wire [31:0] shl = {16'h0, pa[15:0]} << shn;
reg [16:0] x_r;
reg [16:0] y_r;
reg ovf;
reg udf;
reg sc;
reg [15:0] xrev;
reg [4:0] lz;
integer i;
always @*
begin
    x_r = pa;
    y_r = pb;
    ovf = 1'b0;
    udf = 1'b0;
    sc = 1'b0;
    case (op)
    `TALU_OP_OR: x_r = {pa[16], pa[15:0] | pb[15:0]};
    `TALU_OP_AND: x_r = {pa[16], pa[15:0] & pb[15:0]};
    `TALU_OP_XOR: x_r = {pa[16], pa[15:0] ^ pb[15:0]};
    `TALU_OP_ANDN: x_r = {pa[16], ~pa[15:0] & pb[15:0]};
    `TALU_OP_NOT: x_r = {pa[16], ~pa[15:0]};
    `TALU_OP_ADD, `TALU_OP_ADD_LEADING_ZERO_COUNT:
    begin
        x_r = sum[16:0];
        ovf = !sum[17] && sum[16];
        udf = sum[17] && !sum[16];
        sc = op[2];
    end
    `TALU_OP_SUB, `TALU_OP_SUB_LEADING_ZERO_COUNT:
    begin
        x_r = dif[16:0];
        ovf = !dif[17] && dif[16];
        udf = dif[17] && !dif[16];
        sc = op[2];
    end
    `TALU_OP_INC:
    begin
        x_r = inc[16:0];
        ovf = !inc[17] && inc[16];
    end
    `TALU_OP_DEC:
    begin
        x_r = dec[16:0];
        udf = dec[17] && !dec[16];
    end
    `TALU_OP_MUL, `TALU_OP_MUL_LEADING_ZERO_COUNT:
    begin
        x_r = {prod[33], prod[31:16]};
        y_r = {prod[33], prod[15:0]};
        sc = op[2];
    end
    `TALU_OP_PASS_LEADING_ZERO_COUNT: sc = 1'b1;
    `TALU_OP_SHL, `TALU_OP_SHLR, `TALU_OP_SHR, `TALU_OP_SHRR:
    begin
        x_r = {pa[16], pb[16] ? shl[15:0] : shr[31:16]};
        y_r = {pb[16], pb[16] ? shl[31:16] : shr[15:0]};
    end
    default: x_r = pa;
    endcase
    if (op == `TALU_OP_ADD || op == `TALU_OP_SUB || op == `TALU_OP_INC ||
        op == `TALU_OP_DEC || sc)
        y_r = 17'h0;
    // bit-reversed shift variants sit on the odd shift codes
    for (i = 0; i < 16; i = i + 1)
        xrev[i] = x_r[15 - i];
    if (op[4:2] == 3'h1 && op[0])
        x_r = {x_r[16], xrev};
    lz = 5'h10;
    for (i = 0; i < 16; i = i + 1)
        if (x_r[i])
            lz = 5'h0F - i[4:0];
    if (sc)
        y_r = {1'b0, 11'h0, lz};
    if (ovf)
        y_r = 17'h00001;
    else if (udf)
        y_r = 17'h1FFFF;
end
// ****************************************
// condition test
// ****************************************
wire zero = (x_r == 17'h0);
wire neg = x_r[16];
reg hit;
reg cx;
reg cy;
always @*
begin
    case (tst)
    `TALU_TST_EQ: hit = zero;
    `TALU_TST_LT: hit = neg;
    `TALU_TST_LE: hit = neg || zero;
    `TALU_TST_GT: hit = !neg && !zero;
    `TALU_TST_GE: hit = !neg;
    `TALU_TST_NE: hit = !zero;
    `TALU_TST_OVF: hit = ovf || udf;
    default: hit = 1'b0;
    endcase
    cx = (tst == `TALU_TST_NONE) ? pac : hit;
    cy = (tst == `TALU_TST_NONE) ? pbc : hit;
end
// ****************************************
// output sequencing
// ****************************************
localparam ST_IDLE = 2'h0;
localparam ST_ONE = 2'h1;
localparam ST_TWO = 2'h2;
reg [`TALU_ID_W-1:0] id2_q;
reg [17:0] tok2_q;
reg brc_q;
wire take = in_valid && in_ready;
wire give = out_valid && out_ready;
wire [17:0] tx = {cx, x_r};
wire [17:0] ty = {cy, y_r};
wire [17:0] first = (fmt == `TALU_FMT_Y) ? ty : tx;
wire [17:0] second = (fmt == `TALU_FMT_XY) ? ty : tx;
wire [`TALU_ID_W-1:0] in_id1 = in_id + 1'b1;
assign in_ready = enable_q && (state_q == ST_IDLE);
assign out_valid = (state_q != ST_IDLE);
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        state_q <= ST_IDLE;
        count_q <= 16'h0;
        out_id <= {`TALU_ID_W{1'b0}};
        out_data <= 16'h0;
        out_sign <= 1'b0;
        out_cond <= 1'b0;
        id2_q <= {`TALU_ID_W{1'b0}};
        tok2_q <= 18'h0;
        brc_q <= 1'b0;
    end
    else
    begin
        case (state_q)
        ST_IDLE:
        begin
            if (take)
            begin
                state_q <= fmt[1] ? ST_TWO : ST_ONE;
                count_q <= count_q + 16'h0001;
                brc_q <= branch_select;
                {out_cond, out_sign, out_data} <= first;
                out_id <= (branch_select && first[17]) ? in_id1 : in_id;
                tok2_q <= second;
                id2_q <= in_id1;
            end
        end
        ST_TWO:
        begin
            if (give)
            begin
                state_q <= ST_ONE;
                {out_cond, out_sign, out_data} <= tok2_q;
                out_id <= (brc_q && tok2_q[17]) ? id2_q + 1'b1 : id2_q;
            end
        end
        ST_ONE:
            if (give)
                state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
        endcase
    end
end

endmodule // talu_unit

// ==== dv/talu_properties.sv ====
// assertion checker for the token alu unit
`timescale 1ns/1ns
`include "taluv_regs.vh"
module talu_properties (
    input logic aclk,
    input logic aresetn,
    input logic in_valid,
    input logic in_ready,
    input logic [13:0] in_instr,
    input logic [`TALU_ID_W-1:0] in_id,
    input logic [15:0] a_data,
    input logic out_valid,
    input logic out_ready,
    input logic [`TALU_ID_W-1:0] out_id,
    input logic [15:0] out_data,
    input logic out_cond
);
    // ****
    // stream checks
    // ****
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire take = in_valid && in_ready;
    a_take_out:
        assert property (take |=> out_valid) else $error("no token");
    a_token_hold:
        assert property (out_valid && !out_ready |=> out_valid &&
        $stable(out_id) && $stable(out_data)) else $error("token moved");
    a_one_token:
        assert property (take && !in_instr[11] ##1 out_ready |=> !out_valid)
        else $error("extra token");
    a_second_id:
        assert property (take && in_instr[11:9] == 3'h4 ##1 out_ready
        |=> out_id == $past(in_id, 2) + 1'h1) else $error("second id");
    a_plain_id:
        assert property (take && !in_instr[9] |=> out_id == $past(in_id))
        else $error("first id");
    a_branch_id:
        assert property (take && in_instr[9] |=>
        out_id == $past(in_id) + out_cond) else $error("branch id");
    a_both_conds:
        assert property (take && in_instr[11:10] == 2'h3 &&
        in_instr[7:5] != 3'h0 ##1 out_ready |=>
        out_cond == $past(out_cond)) else $error("cond pair");
    a_not_data:
        assert property (take && in_instr[12:8] == 5'h0 &&
        in_instr[4:0] == `TALU_OP_NOT |=> out_data == ~$past(a_data))
        else $error("complement");
    c_two: cover property (take && in_instr[11]);
    c_branch: cover property (take && in_instr[9]);
    c_stall: cover property (out_valid && !out_ready);
endmodule // talu_properties

// ==== dv/talu_sink.sv ====
// downstream token consumer model with optional stalls
`timescale 1ns/1ns
module talu_sink (
    input logic aclk,
    input logic aresetn,
    input logic slow,
    output logic out_ready
);
    logic [1:0] cnt_q;
    // ****
    // acceptance pattern
    // ****
    always @(posedge aclk)
    begin
        if (!aresetn)
            cnt_q <= 2'h0;
        else
            cnt_q <= cnt_q + 2'h1;
    end
    // slow mode takes one token in four cycles
    assign out_ready = !slow || (cnt_q == 2'h3);
endmodule // talu_sink

// ==== dv/talu_unit_bench.sv ====
// self-checking bench for the token alu unit
`timescale 1ns/1ns
`include "taluv_regs.vh"
module talu_unit_bench;
    logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, out_ready;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, in_valid = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, in_ready, out_valid, out_sign, out_cond;
    logic [13:0] in_instr = 14'h0;
    logic [`TALU_ID_W-1:0] in_id = 12'h7FF, out_id;
    logic [15:0] a_data = 16'h0, b_data = 16'h0, out_data;
    logic a_sign = 1'h0, a_cond = 1'h0, b_sign = 1'h0, b_cond = 1'h0;
    int err_count = 0, compares = 0, cyc = 0;
    talu_unit u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .in_valid(in_valid), .in_ready(in_ready), .in_instr(in_instr),
        .in_id(in_id), .a_data(a_data), .a_sign(a_sign), .a_cond(a_cond),
        .b_data(b_data), .b_sign(b_sign), .b_cond(b_cond),
        .out_valid(out_valid), .out_ready(out_ready), .out_id(out_id),
        .out_data(out_data), .out_sign(out_sign), .out_cond(out_cond)
    );
    talu_sink u_sink (.aclk(aclk), .aresetn(aresetn), .slow(slow),
        .out_ready(out_ready));
    always #20 aclk = ~aclk;
    // ****
    // helpers
    // ****
    task chk(input string n, input logic [31:0] s, e);
        begin
            compares++;
            if (s !== e)
            begin
                err_count++;
                $display("BAD %s exp %h seen %h", n, e, s);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", compares, err_count);
            if (err_count == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            tally_and_finish;
        end
    end
    task wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] r);
        begin
            // idle edge so back-to-back calls never set bready twice at once
            @(posedge aclk);
            s_axi_awaddr <= ad;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            fork
                begin
                    do @(posedge aclk); while (!s_axi_awready);
                    s_axi_awvalid <= 1'h0;
                end
                begin
                    do @(posedge aclk); while (!s_axi_wready);
                    s_axi_wvalid <= 1'h0;
                end
            join
            do @(posedge aclk); while (!s_axi_bvalid);
            s_axi_bready <= 1'h0;
            chk("bresp", s_axi_bresp, r);
        end
    endtask
    task rdr(input logic [3:0] ad, input logic [31:0] e, input logic [1:0] r);
        begin
            // idle edge so back-to-back calls never set rready twice at once
            @(posedge aclk);
            s_axi_araddr <= ad;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            do @(posedge aclk); while (!s_axi_arready);
            s_axi_arvalid <= 1'h0;
            do @(posedge aclk); while (!s_axi_rvalid);
            s_axi_rready <= 1'h0;
            chk("rdata", s_axi_rdata, e);
            chk("rresp", s_axi_rresp, r);
        end
    endtask
    task get(input logic [17:0] x, input logic [`TALU_ID_W-1:0] id);
        begin
            do @(posedge aclk); while (!(out_valid && out_ready));
            chk("token", {out_id, out_cond, out_sign, out_data},
                {id, x});
        end
    endtask
    // operands and results are {cond, sign, data}
    task tk(input logic [13:0] i, input logic [17:0] a, b, x, y);
        begin
            in_instr <= i;
            {a_cond, a_sign, a_data} <= a;
            {b_cond, b_sign, b_data} <= b;
            in_valid <= 1'h1;
            do @(posedge aclk); while (!in_ready);
            in_valid <= 1'h0;
            get(x, in_id + (i[9] & x[17]));
            if (i[11])
                get(y, in_id + 1'h1 + (i[9] & y[17]));
            in_id <= in_id + 12'h001;
        end
    endtask
    // ****
    // main sequence
    // ****
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rdr(4'h0, 32'h1, 2'h0);
        rdr(4'h8, 32'h0, 2'h2);
        wr(4'hC, 32'h0, 2'h2);
        wr(4'h0, 32'h0, 2'h0);
        repeat (3) @(posedge aclk);
        chk("in_ready", in_ready, 32'h0);
        wr(4'h0, 32'h1, 2'h0);
        // enable bit only moves when its byte lane is strobed
        s_axi_wstrb <= 4'hE;
        wr(4'h0, 32'h0, 2'h0);
        s_axi_wstrb <= 4'hF;
        rdr(4'h0, 32'h1, 2'h0);
        tk(14'h2000, 18'h0F0F0, 18'h00FF0, 18'h0FFF0, 18'h0);
        tk(14'h2001, 18'h0F0F0, 18'h00FF0, 18'h000F0, 18'h0);
        tk(14'h2002, 18'h0F0F0, 18'h00FF0, 18'h0FF00, 18'h0);
        tk(14'h2003, 18'h0F0F0, 18'h00FF0, 18'h00F00, 18'h0);
        tk(14'h000C, 18'h01234, 18'h35555, 18'h0EDCB, 18'h0);
        tk(14'h2C18, 18'h00005, 18'h20003, 18'h00008, 18'h20000);
        tk(14'h2CF8, 18'h0FFFF, 18'h00001, 18'h30000, 18'h20001);
        tk(14'h2C59, 18'h10000, 18'h00001, 18'h0FFFF, 18'h1FFFF);
        tk(14'h2C1A, 18'h1FFFF, 18'h00002, 18'h1FFFF, 18'h1FFFE);
        tk(14'h3C1B, 18'h2AAAA, 18'h15555, 18'h15555, 18'h2AAAA);
        tk(14'h2D18, 18'h20005, 18'h00003, 18'h20005, 18'h00003);
        tk(14'h2118, 18'h20005, 18'h20003, 18'h20008, 18'h0);
        tk(14'h2222, 18'h01234, 18'h01234, 18'h20000, 18'h0);
        tk(14'h2EC2, 18'h01234, 18'h01234, 18'h00000, 18'h01234);
        tk(14'h241B, 18'h01111, 18'h32222, 18'h32222, 18'h0);
        tk(14'h281B, 18'h01111, 18'h32222, 18'h01111, 18'h01111);
        tk(14'h2C04, 18'h01234, 18'h10004, 18'h02340, 18'h10001);
        tk(14'h2C06, 18'h01234, 18'h00010, 18'h00000, 18'h01234);
        tk(14'h2C0A, 18'h0FFFF, 18'h00000, 18'h10000, 18'h00001);
        tk(14'h2C1C, 18'h00001, 18'h00002, 18'h00003, 18'h0000E);
        tk(14'h0C18, 18'h00005, 18'h20003, 18'h00005, 18'h00000);
        tk(14'h3000, 18'h0F0F0, 18'h00FF0, 18'h0FFF0, 18'h0);
        tk(14'h2C05, 18'h01234, 18'h10004, 18'h002C4, 18'h10001);
        tk(14'h2C0B, 18'h10000, 18'h00000, 18'h0FFFF, 18'h1FFFF);
        tk(14'h2C1B, 18'h2AAAA, 18'h15555, 18'h2AAAA, 18'h15555);
        tk(14'h2C18, 18'h1FFFF, 18'h1FFFE, 18'h1FFFD, 18'h00000);
        for (int t = 1; t < 7; t++)
            tk({6'h20, t[2:0], 5'h1B}, 18'h0, 18'h0, {t[0], 17'h0}, 18'h0);
        slow <= 1'h1;
        tk(14'h2C18, 18'h00005, 18'h20003, 18'h00008, 18'h20000);
        rdr(4'h4, 32'h00210000, 2'h0);
        tally_and_finish;
    end
endmodule // talu_unit_bench
bind talu_unit talu_properties u_props (
    .aclk(aclk), .aresetn(aresetn), .in_valid(in_valid),
    .in_ready(in_ready), .in_instr(in_instr), .in_id(in_id),
    .a_data(a_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_id(out_id), .out_data(out_data), .out_cond(out_cond)
);

// ==== inc/taluv_regs.vh ====
// constants for the token arithmetic/logic unit
`ifndef TALUV_REGS_VH
`define TALUV_REGS_VH
// ****************************************
// token and instruction layout
// ****************************************
`define TALU_ID_W 12
`define TALU_OP_LSB 0
`define TALU_OP_MSB 4
`define TALU_TST_LSB 5
`define TALU_TST_MSB 7
`define TALU_SKIP_BIT 8
`define TALU_BRC_BIT 9
`define TALU_FMT_LSB 10
`define TALU_FMT_MSB 11
`define TALU_SWAP_BIT 12
`define TALU_FULL_BIT 13
// ****************************************
// output formats
// ****************************************
`define TALU_FMT_X 2'h0
`define TALU_FMT_Y 2'h1
`define TALU_FMT_XX 2'h2
`define TALU_FMT_XY 2'h3
// ****************************************
// condition tests
// ****************************************
`define TALU_TST_NONE 3'h0
`define TALU_TST_EQ 3'h1
`define TALU_TST_LT 3'h2
`define TALU_TST_LE 3'h3
`define TALU_TST_GT 3'h4
`define TALU_TST_GE 3'h5
`define TALU_TST_NE 3'h6
`define TALU_TST_OVF 3'h7
// ****************************************
// opcodes
// ****************************************
`define TALU_OP_OR 5'h00
`define TALU_OP_AND 5'h01
`define TALU_OP_XOR 5'h02
`define TALU_OP_ANDN 5'h03
`define TALU_OP_SHL 5'h04
`define TALU_OP_SHLR 5'h05
`define TALU_OP_SHR 5'h06
`define TALU_OP_SHRR 5'h07
`define TALU_OP_INC 5'h0A
`define TALU_OP_DEC 5'h0B
`define TALU_OP_NOT 5'h0C
`define TALU_OP_ADD 5'h18
`define TALU_OP_SUB 5'h19
`define TALU_OP_MUL 5'h1A
`define TALU_OP_NOP 5'h1B
`define TALU_OP_ADD_LEADING_ZERO_COUNT 5'h1C
`define TALU_OP_SUB_LEADING_ZERO_COUNT 5'h1D
`define TALU_OP_MUL_LEADING_ZERO_COUNT 5'h1E
`define TALU_OP_PASS_LEADING_ZERO_COUNT 5'h1F
// ****************************************
// register map
// ****************************************
`define TALU_REG_CTRL 4'h0
`define TALU_REG_STAT 4'h4
`define TALU_CTRL_RST 1'h1
`define TALU_RESP_OK 2'h0
`define TALU_RESP_ERR 2'h2
`endif
